/* File: pcsp_channel.v */
// Summary of operation
// - load/store access drives option outputs from instruction bits 18,17,16.
// - option codes: word, byte, half, rom-data, cache, debug; others reserved.
// - vector fetch presents the word-length option code.
// - stores aimed at instruction rom are never blocked here.
// - pipelined-data indicator marks a data access held behind one in flight.
// - pipelined data access completes after the first; marked by data request.
// - pipelined-instruction indicator likewise; promotion marked by instruction request.
// - a pipelined access starts only while pipeline enable allows it.
// - direction high for reads, low for writes, high on instruction requests.
// - asynchronous reset puts the processor into reset mode.
// - execution status shows the previous cycle's execute-stage state.
// - privilege output shows supervisor or user mode of each access.
// - no bus grant starts while lock is active; a grant already given stays while bus request is held.
// - generated system clock is half the oscillator rate, else taken as input.
// - clock-driver supply strap selects generate or accept system clock.
// - test input floats every output except the compare error output.
// - two prioritized trap inputs, lower index wins, ignored under disable-all.
// - falling edge on warn raises a non-maskable trap without vector fetch.
// - four-stage pipeline, one completion per cycle, hardware interlock.
// - one shared address bus, separate instruction and data buses.
// - address bus released before completion; at most three accesses in flight.
// - data request type: memory, io, coprocessor; valid with data request.
// - bus grant output tells a master the channel has been given up.
`timescale 1ns/100ps
`default_nettype none
`include "pcsp_defines.vh"

module pcsp_channel #(
  parameter AW = `PCSP_ADDR_W,
  parameter DW = `PCSP_BUS_W
) (
  input  wire          mclk_i,
  input  wire          reset_i,
  // core side
  input  wire          ifetch_valid_i,
  input  wire [AW-1:0] ifetch_addr_i,
  output wire          ifetch_ready_o,
  output reg  [DW-1:0] instr_word_o,
  output reg           instr_valid_o,
  input  wire          dacc_valid_i,
  input  wire [AW-1:0] dacc_addr_i,
  input  wire [DW-1:0] dacc_instr_i,
  input  wire          dacc_store_i,
  input  wire [1:0]    dacc_type_i,
  input  wire          dacc_vector_i,
  input  wire          dacc_lock_i,
  input  wire [DW-1:0] dacc_wdata_i,
  output wire          dacc_ready_o,
  output reg  [DW-1:0] load_data_o,
  output reg           load_valid_o,
  input  wire          supervisor_i,
  input  wire          lock_hold_i,
  input  wire [2:0]    exec_state_i,
  input  wire          disable_all_bit_i,
  input  wire          hazard_i,
  output reg  [1:0]    trap_take_o,
  output reg           warn_trap_o,
  output reg           retire_o,
  output reg           reset_mode_o,
  output wire          sys_tick_o,
  // channel pins
  output reg  [AW-1:0] address_o,
  output reg           instruction_request_o,
  output reg           data_request_o,
  output reg  [1:0]    data_request_type_o,
  output reg  [2:0]    access_option_code_o,
  output reg           read_write_o,
  output reg           pipelined_instruction_indicator_o,
  output reg           pipelined_data_indicator_o,
  output reg           privilege_level_o,
  output reg           lock_o,
  output wire          chan_oe_o,
  input  wire [DW-1:0] instruction_bus_i,
  input  wire          instruction_ready_i,
  input  wire [DW-1:0] data_bus_i,
  output reg  [DW-1:0] data_bus_o,
  output wire          data_bus_oe_o,
  input  wire          data_ready_i,
  input  wire          pipeline_enable_i,
  input  wire          bus_request_i,
  output reg           bus_grant_o,
  output reg  [2:0]    execution_status_o,
  output wire          plain_oe_o,
  output wire          master_slave_compare_error_o,
  input  wire [1:0]    trap_request_inputs_i,
  input  wire          warn_i,
  input  wire          test_i,
  input  wire          clock_driver_supply_i,
  input  wire          oscillator_input_i,
  input  wire          system_clock_i,
  output reg           system_clock_o,
  output wire          system_clock_oe_o
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function [2:0] opt_of;
    input          vec;
    input [DW-1:0] instr;
    begin
      if (vec)
        opt_of = `PCSP_OPT_WORD;
      else
        opt_of = instr[`PCSP_OPT_HI:`PCSP_OPT_LO];
    end
  endfunction

  // ----------------------------------------------------------------
  // synchronisers for pins from outside the clock domain
  // ----------------------------------------------------------------
  // bit order: system_clock_in, osc, strap, test, warn, trap_request_inputs
  reg  [6:0] sync1;
  reg  [6:0] sync2;
  reg        osc_d;
  reg        sclk_d;
  reg        warn_d;
  wire       test_s  = sync2[3];
  wire       warn_s  = sync2[2];
  wire [1:0] trap_s  = sync2[1:0];

  // the chain keeps running through reset, so the strap and the warn
  // level are settled when reset lets go; a cleared chain would read
  // a grounded strap and a false warn edge at release
  always @(posedge mclk_i) begin
    sync1 <= {system_clock_i, oscillator_input_i,
              clock_driver_supply_i, test_i, warn_i,
              trap_request_inputs_i};
    sync2 <= sync1;
  end

  always @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      osc_d  <= 1'b0;
      sclk_d <= 1'b0;
      warn_d <= 1'b1;
    end else begin
      osc_d  <= sync2[5];
      sclk_d <= sync2[6];
      warn_d <= warn_s;
    end
  end

  // ----------------------------------------------------------------
  // clock source and channel tick
  // ----------------------------------------------------------------
  // the strap is caught once, after reset release, so that a late
  // settling supply pin cannot switch the clock mid-run
  reg  gen_mode;
  reg  strap_taken;
  wire osc_rise  = sync2[5] & ~osc_d;
  wire sclk_rise = sync2[6] & ~sclk_d;
  wire tick;

  always @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      gen_mode       <= 1'b0;
      strap_taken    <= 1'b0;
      system_clock_o <= 1'b0;
      reset_mode_o   <= 1'b1;
    end else begin
      if (!strap_taken) begin
        gen_mode    <= sync2[4];
        strap_taken <= 1'b1;
      end else begin
        reset_mode_o <= 1'b0;
      end
      if (gen_mode && osc_rise)
        system_clock_o <= ~system_clock_o;
    end
  end

  // in accept mode the system clock is only sampled, so its rate must
  // stay well below half of mclk for edges to be seen
  assign tick = strap_taken &
                (gen_mode ? (osc_rise & ~system_clock_o)
                          : sclk_rise);
  assign sys_tick_o = tick;

  // ----------------------------------------------------------------
  // test float and output enables
  // ----------------------------------------------------------------
  reg  d_store;
  reg  d_busy;
  assign chan_oe_o         = ~test_s & ~bus_grant_o;
  assign plain_oe_o        = ~test_s;
  assign system_clock_oe_o = gen_mode & ~test_s;
  assign data_bus_oe_o     = chan_oe_o & d_busy & d_store;
  // no lockstep partner here, so drivers always agree
  assign master_slave_compare_error_o = 1'b0;

  // ----------------------------------------------------------------
  // channel scheduler
  // ----------------------------------------------------------------
  reg           i_busy;
  reg           i_pipe;
  reg           d_pipe;
  reg           d_lock;
  reg           dp_store;
  reg           dp_lock;
  reg  [DW-1:0] dp_wdata;

  wire i_done = i_busy & instruction_ready_i;
  wire d_done = d_busy & data_ready_i;
  wire i_left = i_busy & ~i_done;
  wire d_left = d_busy & ~d_done;
  wire idle   = ~i_busy & ~d_busy & ~i_pipe & ~d_pipe;
  wire lock_n = lock_hold_i | (d_busy & d_lock);

  wire promote_i = i_pipe & i_done;
  wire promote_d = d_pipe & d_done & ~promote_i;
  wire grant_now = bus_request_i & ~lock_o & idle;
  wire bus_free  = ~i_pipe & ~d_pipe & ~bus_grant_o &
                   ~grant_now & ~bus_request_i;

  // data has priority on the shared address bus
  wire d_issue = bus_free & dacc_valid_i & ~d_left;
  wire d_hold  = bus_free & dacc_valid_i & d_left &
                 pipeline_enable_i;
  wire d_take  = d_issue | d_hold;
  wire i_issue = bus_free & ~d_take & ifetch_valid_i & ~i_left;
  wire i_hold  = bus_free & ~d_take & ifetch_valid_i & i_left &
                 pipeline_enable_i;

  assign dacc_ready_o   = tick & d_take;
  assign ifetch_ready_o = tick & (i_issue | i_hold);

  always @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      i_busy      <= 1'b0;
      i_pipe      <= 1'b0;
      d_busy      <= 1'b0;
      d_pipe      <= 1'b0;
      d_store     <= 1'b0;
      d_lock      <= 1'b0;
      dp_store    <= 1'b0;
      dp_lock     <= 1'b0;
      dp_wdata    <= {DW{1'b0}};
      bus_grant_o <= 1'b0;
      lock_o      <= 1'b0;
      address_o   <= {AW{1'b0}};
      instruction_request_o <= 1'b0;
      data_request_o        <= 1'b0;
      data_request_type_o   <= `PCSP_DRT_MEM;
      access_option_code_o  <= `PCSP_OPT_WORD;
      read_write_o          <= 1'b1;
      pipelined_instruction_indicator_o <= 1'b0;
      pipelined_data_indicator_o        <= 1'b0;
      privilege_level_o <= 1'b1;
      data_bus_o        <= {DW{1'b0}};
      instr_word_o      <= {DW{1'b0}};
      instr_valid_o     <= 1'b0;
      load_data_o       <= {DW{1'b0}};
      load_valid_o      <= 1'b0;
    end else begin
      instr_valid_o <= 1'b0;
      load_valid_o  <= 1'b0;
      if (tick) begin
        // requests are single-cycle; the address is then released
        instruction_request_o <= 1'b0;
        data_request_o        <= 1'b0;
        lock_o <= lock_n;
        if (grant_now)
          bus_grant_o <= 1'b1;
        else if (!bus_request_i)
          bus_grant_o <= 1'b0;
        if (i_done) begin
          instr_word_o  <= instruction_bus_i;
          instr_valid_o <= 1'b1;
          i_busy        <= i_pipe;
        end
        if (d_done) begin
          if (!d_store) begin
            load_data_o  <= data_bus_i;
            load_valid_o <= 1'b1;
          end
          d_busy <= d_pipe & ~promote_i;
        end
        if (promote_i) begin
          i_pipe <= 1'b0;
          pipelined_instruction_indicator_o <= 1'b0;
          instruction_request_o <= 1'b1;
        end else if (promote_d) begin
          d_pipe     <= 1'b0;
          d_store    <= dp_store;
          d_lock     <= dp_lock;
          data_bus_o <= dp_wdata;
          pipelined_data_indicator_o <= 1'b0;
          data_request_o <= 1'b1;
        end else if (d_take) begin
          address_o           <= dacc_addr_i;
          read_write_o        <= ~dacc_store_i;
          data_request_type_o <= dacc_vector_i ? `PCSP_DRT_MEM
                                               : dacc_type_i;
          // rom-targeted stores pass through unchecked
          access_option_code_o <= opt_of(dacc_vector_i,
                                         dacc_instr_i);
          privilege_level_o <= supervisor_i;
          if (d_issue) begin
            d_busy         <= 1'b1;
            d_store        <= dacc_store_i;
            d_lock         <= dacc_lock_i;
            data_bus_o     <= dacc_wdata_i;
            data_request_o <= 1'b1;
          end else begin
            d_pipe   <= 1'b1;
            dp_store <= dacc_store_i;
            dp_lock  <= dacc_lock_i;
            dp_wdata <= dacc_wdata_i;
            pipelined_data_indicator_o <= 1'b1;
          end
        end else if (i_issue || i_hold) begin
          address_o         <= ifetch_addr_i;
          read_write_o      <= 1'b1;
          privilege_level_o <= supervisor_i;
          if (i_issue) begin
            i_busy <= 1'b1;
            instruction_request_o <= 1'b1;
          end else begin
            i_pipe <= 1'b1;
            pipelined_instruction_indicator_o <= 1'b1;
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // execution status, traps and warn
  // ----------------------------------------------------------------
  wire warn_fall = warn_d & ~warn_s;

  always @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      execution_status_o <= `PCSP_ST_HALT;
      trap_take_o        <= 2'h0;
      warn_trap_o        <= 1'b0;
    end else begin
      // a warn edge between ticks must not be lost, so it is not gated
      warn_trap_o <= warn_fall;
      if (tick) begin
        execution_status_o <= exec_state_i;
        if (disable_all_bit_i)
          trap_take_o <= 2'h0;
        else if (trap_s[0])
          trap_take_o <= 2'h1;
        else if (trap_s[1])
          trap_take_o <= 2'h2;
        else
          trap_take_o <= 2'h0;
      end
    end
  end

  // ----------------------------------------------------------------
  // instruction pipeline occupancy
  // ----------------------------------------------------------------
  // a hazard freezes every stage; bubbles are not squeezed out, which
  // costs a cycle but keeps the interlock a single enable
  reg [`PCSP_STAGES-1:0] stage;
  reg                    fetched;

  always @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      stage    <= {`PCSP_STAGES{1'b0}};
      fetched  <= 1'b0;
      retire_o <= 1'b0;
    end else begin
      if (instr_valid_o)
        fetched <= 1'b1;
      retire_o <= 1'b0;
      if (tick && !hazard_i) begin
        stage    <= {stage[`PCSP_STAGES-2:0], fetched};
        retire_o <= stage[`PCSP_STAGES-1];
        if (!instr_valid_o)
          fetched <= 1'b0;
      end
    end
  end

endmodule // pcsp_channel
`default_nettype wire

/* File: pcsp_channel_asserts.sv */
`timescale 1ns/100ps
`default_nettype none
module pcsp_channel_asserts (
  input wire logic        mclk_i,
  input wire logic        reset_i,
  input wire logic        dacc_ready_o,
  input wire logic        dacc_vector_i,
  input wire logic [31:0] dacc_instr_i,
  input wire logic [2:0]  access_option_code_o,
  input wire logic [1:0]  data_request_type_o,
  input wire logic        data_request_o,
  input wire logic        pipelined_data_indicator_o,
  input wire logic        pipeline_enable_i,
  input wire logic        sys_tick_o,
  input wire logic [2:0]  exec_state_i,
  input wire logic [2:0]  execution_status_o,
  input wire logic        bus_grant_o,
  input wire logic        chan_oe_o,
  input wire logic        plain_oe_o,
  input wire logic        system_clock_oe_o,
  input wire logic        test_i
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  // ----------------------------------------------------------------
  // channel pin relations
  // ----------------------------------------------------------------
  property p_opt_bits;
    dacc_ready_o && !dacc_vector_i
      |=> access_option_code_o == $past(dacc_instr_i[18:16]);
  endproperty
  a_opt_bits: assert property (p_opt_bits) else $error("option code");
  property p_vec_word;
    dacc_ready_o && dacc_vector_i
      |=> access_option_code_o == 3'h0 && data_request_type_o == 2'h0;
  endproperty
  a_vec_word: assert property (p_vec_word) else $error("vector code");
  property p_pda_quiet;
    pipelined_data_indicator_o |-> !data_request_o;
  endproperty
  a_pda_quiet: assert property (p_pda_quiet) else $error("pda with data_request");
  property p_pda_promote;
    $fell(pipelined_data_indicator_o) |-> data_request_o;
  endproperty
  a_pda_promote: assert property (p_pda_promote) else $error("no promote");
  property p_pen_gate;
    $rose(pipelined_data_indicator_o) |-> $past(pipeline_enable_i);
  endproperty
  a_pen_gate: assert property (p_pen_gate) else $error("pipelined, no pen");
  property p_status;
    sys_tick_o |=> execution_status_o == $past(exec_state_i);
  endproperty
  a_status: assert property (p_status) else $error("status lag");
  property p_grant_oe;
    bus_grant_o |-> !chan_oe_o;
  endproperty
  a_grant_oe: assert property (p_grant_oe) else $error("granted, driving");
  property p_test_float;
    test_i [*3] |-> !(chan_oe_o || plain_oe_o || system_clock_oe_o);
  endproperty
  a_test_float: assert property (p_test_float) else $error("test drive");
endmodule // pcsp_channel_asserts
bind pcsp_channel pcsp_channel_asserts u_chk (.*);
`default_nettype wire

/* File: pcsp_channel_test.sv */
`timescale 1ns/100ps
`default_nettype none
module pcsp_channel_test;
  logic mclk_i = 0, reset_i = 1, ifetch_valid_i = 0, dacc_valid_i = 0;
  logic dacc_store_i = 0, dacc_vector_i = 0, dacc_lock_i = 0, hazard_i = 0;
  logic supervisor_i = 0, lock_hold_i = 0, disable_all_bit_i = 0, test_i = 0;
  logic pipeline_enable_i = 0, bus_request_i = 0, warn_i = 1, slow = 0;
  logic clock_driver_supply_i = 1, oscillator_input_i = 0, pipe = 0;
  logic [31:0] ifetch_addr_i = 0, dacc_addr_i = 0, a = 0;
  logic [31:0] dacc_instr_i = 0, dacc_wdata_i = 0;
  logic [2:0]  exec_state_i = 0;
  logic [1:0]  dacc_type_i = 0, trap_request_inputs_i = 0;
  wire  [31:0] instr_word_o, load_data_o, address_o, data_bus_o;
  wire  [31:0] instruction_bus_i, data_bus_i;
  wire  [2:0]  access_option_code_o, execution_status_o;
  wire  [1:0]  trap_take_o, data_request_type_o;
  wire ifetch_ready_o, instr_valid_o, dacc_ready_o, load_valid_o, lock_o;
  wire warn_trap_o, retire_o, reset_mode_o, sys_tick_o, read_write_o;
  wire instruction_request_o, data_request_o, privilege_level_o, chan_oe_o;
  wire pipelined_instruction_indicator_o, pipelined_data_indicator_o;
  wire data_bus_oe_o, instruction_ready_i, data_ready_i, bus_grant_o;
  wire plain_oe_o, master_slave_compare_error_o, system_clock_o;
  wire system_clock_oe_o;
  wire system_clock_i = oscillator_input_i;
  int  fails = 0, checks_done = 0, cnt;
  time t0;
  pcsp_channel u_dut (.*);
  pcsp_mem_port u_imem (.mclk_i(mclk_i), .tick_i(sys_tick_o), .slow_i(slow),
    .req_i(instruction_request_o), .addr_i(address_o),
    .data_o(instruction_bus_i), .rdy_o(instruction_ready_i));
  pcsp_mem_port u_dmem (.mclk_i(mclk_i), .tick_i(sys_tick_o), .slow_i(slow),
    .req_i(data_request_o), .addr_i(address_o),
    .data_o(data_bus_i), .rdy_o(data_ready_i));
  initial forever #2.5 mclk_i = ~mclk_i;
  initial begin
    #1;
    forever #10 oscillator_input_i = ~oscillator_input_i;
  end
  // ----------------------------------------------------------------
  // access tasks
  // ----------------------------------------------------------------
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task wrap_up;
    if (fails == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task ticks(input int n);
    repeat (n) begin
      @(negedge mclk_i iff sys_tick_o);
      @(negedge mclk_i);
    end
  endtask
  task d_go(input logic [31:0] ad, input logic [2:0] o, input logic st,
            input logic vec, input logic sup, input logic [1:0] ty);
    dacc_addr_i = ad;
    dacc_instr_i = {13'h0aab, o, 16'h5555};
    dacc_wdata_i = ad ^ 32'hff00ff00;
    {dacc_store_i, dacc_vector_i, supervisor_i, dacc_type_i} = {st, vec, sup, ty};
    dacc_valid_i = 1'b1;
    @(negedge mclk_i iff dacc_ready_o);
    @(negedge mclk_i);
    dacc_valid_i = 1'b0;
    check(address_o, ad);
    check({data_request_o, pipelined_data_indicator_o}, {!pipe, pipe});
    check(read_write_o, !st);
    check(access_option_code_o, vec ? 3'h0 : o);
    check(data_request_type_o, vec ? 2'h0 : ty);
    check(privilege_level_o, sup);
  endtask
  task d_done(input logic [31:0] ad, input logic st);
    if (st) begin
      @(negedge mclk_i iff (data_ready_i && sys_tick_o));
      check(data_bus_o, ad ^ 32'hff00ff00);
      @(negedge mclk_i);
    end else begin
      @(negedge mclk_i iff load_valid_o);
      check(load_data_o, ~ad);
    end
  endtask
  task i_go(input logic [31:0] ad);
    ifetch_addr_i = ad;
    ifetch_valid_i = 1'b1;
    @(negedge mclk_i iff ifetch_ready_o);
    @(negedge mclk_i);
    ifetch_valid_i = 1'b0;
    check(address_o, ad);
    check({instruction_request_o, pipelined_instruction_indicator_o},
          {!pipe, pipe});
    if (!pipe) check(read_write_o, 1'b1);
  endtask
  task i_done(input logic [31:0] ad);
    @(negedge mclk_i iff instr_valid_o);
    check(instr_word_o, ~ad);
  endtask
  // ----------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------
  initial begin
    #100000;
    fails++;
    wrap_up;
  end
  initial begin
    repeat (10) @(negedge mclk_i);
    check(reset_mode_o, 1'b1);
    reset_i = 1'b0;
    ticks(2);
    @(posedge system_clock_o);
    t0 = $time;
    @(posedge system_clock_o);
    check(32'($time - t0), 32'h28);
    @(negedge mclk_i);
    check(system_clock_oe_o, 1'b1);
    for (int i = 0; i < 8; i++) begin
      a = 32'h100 + 32'(i * 4);
      dacc_lock_i = i[0];
      d_go(a, 3'(i), i[2], 1'b0, i[1], 2'(i));
      d_done(a, i[2]);
    end
    d_go(32'h200, 3'h5, 1'b0, 1'b1, 1'b1, 2'h1);
    d_done(32'h200, 1'b0);
    {slow, pipeline_enable_i} = 2'h3;
    d_go(32'h300, 3'h0, 1'b0, 1'b0, 1'b0, 2'h0);
    pipe = 1'b1;
    d_go(32'h304, 3'h0, 1'b0, 1'b0, 1'b0, 2'h0);
    pipe = 1'b0;
    d_done(32'h300, 1'b0);
    d_done(32'h304, 1'b0);
    pipeline_enable_i = 1'b0;
    d_go(32'h308, 3'h0, 1'b0, 1'b0, 1'b0, 2'h0);
    d_go(32'h30c, 3'h0, 1'b1, 1'b0, 1'b0, 2'h0);
    d_done(32'h30c, 1'b1);
    pipeline_enable_i = 1'b1;
    i_go(32'h400);
    pipe = 1'b1;
    i_go(32'h404);
    pipe = 1'b0;
    i_done(32'h400);
    i_done(32'h404);
    for (int s = 0; s < 8; s++) begin
      exec_state_i = 3'(s);
      ticks(1);
      check(execution_status_o, 32'(s));
    end
    for (int j = 0; j < 8; j++) begin
      trap_request_inputs_i = 2'(j);
      disable_all_bit_i = j[2];
      ticks(2);
      check(trap_take_o, j[2] ? 2'h0 : j[0] ? 2'h1 : {j[1], 1'b0});
    end
    {trap_request_inputs_i, disable_all_bit_i, warn_i} = 4'h0;
    cnt = 0;
    repeat (8) begin
      @(negedge mclk_i);
      cnt += warn_trap_o;
    end
    check(32'(cnt), 32'h1);
    warn_i = 1'b1;
    lock_hold_i = 1'b1;
    ticks(1);
    check(lock_o, 1'b1);
    bus_request_i = 1'b1;
    ticks(4);
    check(bus_grant_o, 1'b0);
    lock_hold_i = 1'b0;
    @(negedge mclk_i iff bus_grant_o);
    check(chan_oe_o, 1'b0);
    bus_request_i = 1'b0;
    ticks(2);
    check(bus_grant_o, 1'b0);
    test_i = 1'b1;
    repeat (3) @(negedge mclk_i);
    check({chan_oe_o, plain_oe_o, system_clock_oe_o,
           master_slave_compare_error_o}, 4'h0);
    test_i = 1'b0;
    repeat (3) @(negedge mclk_i);
    check(chan_oe_o, 1'b1);
    {clock_driver_supply_i, reset_i, slow} = 3'h2;
    repeat (10) @(negedge mclk_i);
    check(reset_mode_o, 1'b1);
    reset_i = 1'b0;
    i_go(32'h500);
    i_done(32'h500);
    check(system_clock_oe_o, 1'b0);
    check(reset_mode_o, 1'b0);
    wrap_up;
  end
endmodule // pcsp_channel_test
`default_nettype wire

/* File: pcsp_defines.vh */
`ifndef PCSP_DEFINES_VH
`define PCSP_DEFINES_VH

// ----------------------------------------------------------------
// bus widths
// ----------------------------------------------------------------
`define PCSP_ADDR_W        32
`define PCSP_BUS_W         32

// ----------------------------------------------------------------
// option field position inside a load/store instruction word
// ----------------------------------------------------------------
`define PCSP_OPT_HI        18
`define PCSP_OPT_LO        16

// ----------------------------------------------------------------
// access option codes
// ----------------------------------------------------------------
`define PCSP_OPT_WORD      3'h0
`define PCSP_OPT_BYTE      3'h1
`define PCSP_OPT_HALF      3'h2
`define PCSP_OPT_ROM_DATA  3'h4
`define PCSP_OPT_CACHE     3'h5
`define PCSP_OPT_DEBUG     3'h6

// ----------------------------------------------------------------
// data request types
// ----------------------------------------------------------------
`define PCSP_DRT_MEM       2'h0
`define PCSP_DRT_IO        2'h1
`define PCSP_DRT_COPRO     2'h2

// ----------------------------------------------------------------
// execution status codes
// ----------------------------------------------------------------
`define PCSP_ST_HALT       3'h0
`define PCSP_ST_HOLD       3'h1
`define PCSP_ST_LOADTEST   3'h2
`define PCSP_ST_WAIT       3'h3
`define PCSP_ST_IRET       3'h4
`define PCSP_ST_TRAP       3'h5
`define PCSP_ST_NONSEQ     3'h6
`define PCSP_ST_EXEC       3'h7

// ----------------------------------------------------------------
// pipeline depth
// ----------------------------------------------------------------
`define PCSP_STAGES        4

`endif

/* File: pcsp_mem_port.sv */
`timescale 1ns/100ps
`default_nettype none
module pcsp_mem_port (
  input  wire logic        mclk_i,
  input  wire logic        tick_i,
  input  wire logic        slow_i,
  input  wire logic        req_i,
  input  wire logic [31:0] addr_i,
  output logic      [31:0] data_o = 32'h0,
  output logic             rdy_o = 1'b0
);
  // ----------------------------------------------------------------
  // one access at a time, answered on channel ticks
  // ----------------------------------------------------------------
  logic [31:0] held = 32'h0;
  logic [1:0]  wait_left = 2'h0;
  logic        busy = 1'b0;
  always @(posedge mclk_i) begin
    // a released bus never holds a stale word
    if (!rdy_o) data_o <= ~data_o;
    if (tick_i) begin
      rdy_o <= 1'b0;
      if (req_i) begin
        busy <= 1'b1;
        held <= addr_i;
        wait_left <= slow_i ? 2'h3 : 2'h0;
      end else if (busy && wait_left != 2'h0) begin
        wait_left <= wait_left - 2'h1;
      end else if (busy) begin
        busy <= 1'b0;
        rdy_o <= 1'b1;
        data_o <= ~held;
      end
    end
  end
endmodule // pcsp_mem_port
`default_nettype wire
